//--- src/sbsr_pkg.sv
// Constants and types of the status byte block
package sbsr_pkg;
   localparam int STB_W = 8;
   localparam int SCPI_W = 16;
   localparam int ESR_W = 8;

   localparam int BIT_DEV = 0;
   localparam int BIT_EAV = 2;
   localparam int BIT_QUES = 3;
   localparam int BIT_MAV = 4;
   localparam int BIT_ESB = 5;
   localparam int BIT_MSS = 6;
   localparam int BIT_OPER = 7;

   localparam logic [7:0] MSS_MASK = 8'h40;
   localparam logic [7:0] STB_RST = 8'h00;
   localparam logic [7:0] SRE_RST = 8'h00;
   localparam logic [7:0] PPE_RST = 8'h00;

   typedef enum logic [2:0] {
      OP_SRE_WR,
      OP_SRE_RD,
      OP_PRE_WR,
      OP_PRE_RD,
      OP_STB_RD,
      OP_IST_RD,
      OP_SPOLL,
      OP_PPOLL
   } sbsr_op_t;

   typedef struct packed {
      logic valid;
      sbsr_op_t op;
      logic [7:0] data;
   } sbsr_cmd_t;

   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } sbsr_rsp_t;

   typedef struct packed {
      logic [SCPI_W-1:0] evt;
      logic [SCPI_W-1:0] ena;
   } sbsr_scpi_t;

   typedef struct packed {
      logic [ESR_W-1:0] evt;
      logic [ESR_W-1:0] ena;
   } sbsr_esr_t;
endpackage

//--- src/sbsr_sum.sv
// Sum bit of one lower status register: event AND enable, ORed
`timescale 1ns/1ps
module sbsr_sum #(
   parameter int W = 16
) (
   input wire logic [W-1:0] evt,
   input wire logic [W-1:0] ena,
   output logic sum
);
   logic [W-1:0] hit;

   genvar i;
   generate
      for (i = 0; i < W; i++) begin : g_bit
         assign hit[i] = evt[i] & ena[i];
      end
   endgenerate

   assign sum = |hit;
endmodule

//--- src/sbsr_top.sv
// Status byte, service request and parallel poll flag logic
`timescale 1ns/1ps
module sbsr_top (
   input wire logic clk,
   input wire logic rst_n,
   input wire sbsr_pkg::sbsr_cmd_t cmd,
   input wire sbsr_pkg::sbsr_scpi_t dev,
   input wire sbsr_pkg::sbsr_scpi_t ques,
   input wire sbsr_pkg::sbsr_scpi_t oper,
   input wire sbsr_pkg::sbsr_esr_t esr,
   input wire logic err_not_empty,
   input wire logic err_push,
   input wire logic msg_avail,
   output sbsr_pkg::sbsr_rsp_t rsp,
   output logic srq,
   output logic ist
);
   logic dev_sum;
   logic ques_sum;
   logic oper_sum;
   logic esb_sum;

   logic [7:0] sre_r;
   logic [7:0] sre_nxt;
   logic [7:0] ppe_r;
   logic [7:0] ppe_nxt;
   logic [7:0] stb_r;
   logic [7:0] stb_nxt;
   logic [7:0] prev_r;
   logic [7:0] prev_nxt;
   logic srq_r;
   logic srq_nxt;
   logic ist_r;
   logic ist_nxt;
   sbsr_pkg::sbsr_rsp_t rsp_r;
   sbsr_pkg::sbsr_rsp_t rsp_nxt;

   logic mss;
   logic [7:0] stb_full;
   logic [7:0] rise;
   logic req;
   logic spoll;

   // Lower register summaries
   sbsr_sum #(.W(sbsr_pkg::SCPI_W)) u_dev (
      .evt(dev.evt),
      .ena(dev.ena),
      .sum(dev_sum)
   );

   sbsr_sum #(.W(sbsr_pkg::SCPI_W)) u_ques (
      .evt(ques.evt),
      .ena(ques.ena),
      .sum(ques_sum)
   );

   sbsr_sum #(.W(sbsr_pkg::SCPI_W)) u_oper (
      .evt(oper.evt),
      .ena(oper.ena),
      .sum(oper_sum)
   );

   sbsr_sum #(.W(sbsr_pkg::ESR_W)) u_esr (
      .evt(esr.evt),
      .ena(esr.ena),
      .sum(esb_sum)
   );

   // Enable masks, written by common commands
   always_comb begin
      sre_nxt = sre_r;
      ppe_nxt = ppe_r;
      if (cmd.valid && cmd.op == sbsr_pkg::OP_SRE_WR) begin
         sre_nxt = cmd.data;
      end
      if (cmd.valid && cmd.op == sbsr_pkg::OP_PRE_WR) begin
         ppe_nxt = cmd.data;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sre_r <= sbsr_pkg::SRE_RST;
         ppe_r <= sbsr_pkg::PPE_RST;
      end else begin
         sre_r <= sre_nxt;
         ppe_r <= ppe_nxt;
      end
   end

   // Current condition bits; bit 6 is never stored, it is derived below
   always_comb begin
      stb_nxt = sbsr_pkg::STB_RST;
      stb_nxt[sbsr_pkg::BIT_DEV] = dev_sum;
      stb_nxt[sbsr_pkg::BIT_EAV] = err_not_empty;
      stb_nxt[sbsr_pkg::BIT_QUES] = ques_sum;
      stb_nxt[sbsr_pkg::BIT_MAV] = msg_avail;
      stb_nxt[sbsr_pkg::BIT_ESB] = esb_sum;
      stb_nxt[sbsr_pkg::BIT_OPER] = oper_sum;
      prev_nxt = stb_full;
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stb_r <= sbsr_pkg::STB_RST;
         prev_r <= sbsr_pkg::STB_RST;
      end else begin
         stb_r <= stb_nxt;
         prev_r <= prev_nxt;
      end
   end

   // Master summary ignores enable bit 6 so it cannot feed itself
   assign mss = |(stb_r & sre_r & ~sbsr_pkg::MSS_MASK);

   always_comb begin
      stb_full = stb_r;
      stb_full[sbsr_pkg::BIT_MSS] = mss;
   end

   assign rise = stb_full & ~prev_r;
   // A push while the bit is already 1 would show no edge, hence the pulse
   assign req = (|(rise & sre_r & ~sbsr_pkg::MSS_MASK))
      | (err_push & sre_r[sbsr_pkg::BIT_EAV]);
   assign spoll = cmd.valid && cmd.op == sbsr_pkg::OP_SPOLL;

   // Service request: held until a serial poll; a new request wins
   always_comb begin
      srq_nxt = srq_r;
      if (spoll) begin
         srq_nxt = 1'b0;
      end
      if (req) begin
         srq_nxt = 1'b1;
      end
      ist_nxt = |(stb_full & ppe_r);
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         srq_r <= 1'b0;
         ist_r <= 1'b0;
      end else begin
         srq_r <= srq_nxt;
         ist_r <= ist_nxt;
      end
   end

   // Query answers, one cycle after the command
   always_comb begin
      rsp_nxt.valid = 1'b0;
      rsp_nxt.data = 8'h00;
      if (cmd.valid) begin
         unique case (cmd.op)
            sbsr_pkg::OP_SRE_RD: begin
               rsp_nxt.valid = 1'b1;
               rsp_nxt.data = sre_r;
            end
            sbsr_pkg::OP_PRE_RD: begin
               rsp_nxt.valid = 1'b1;
               rsp_nxt.data = ppe_r;
            end
            sbsr_pkg::OP_STB_RD, sbsr_pkg::OP_SPOLL: begin
               rsp_nxt.valid = 1'b1;
               rsp_nxt.data = stb_full;
            end
            sbsr_pkg::OP_IST_RD, sbsr_pkg::OP_PPOLL: begin
               rsp_nxt.valid = 1'b1;
               rsp_nxt.data = {7'h00, ist_r};
            end
            sbsr_pkg::OP_SRE_WR, sbsr_pkg::OP_PRE_WR: begin
               rsp_nxt.valid = 1'b0;
            end
         endcase
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         rsp_r <= '0;
      end else begin
         rsp_r <= rsp_nxt;
      end
   end

   assign rsp = rsp_r;
   assign srq = srq_r;
   assign ist = ist_r;

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   mss_summary_a: assert property (
      ##1 stb_full[sbsr_pkg::BIT_MSS]
         == |($past(stb_nxt) & sre_r & ~sbsr_pkg::MSS_MASK))
      else $error("master summary does not match enabled bits");

   stb_query_a: assert property (
      cmd.valid && cmd.op == sbsr_pkg::OP_STB_RD
         |=> rsp.valid && rsp.data == $past(stb_full))
      else $error("status byte query answer wrong");

   sre_bit6_a: assert property (
      sre_r == sbsr_pkg::MSS_MASK |-> !stb_full[sbsr_pkg::BIT_MSS])
      else $error("enable bit 6 alone set the master summary");

   srq_raise_a: assert property (
      |(rise & sre_r & ~sbsr_pkg::MSS_MASK) |=> srq)
      else $error("enabled rising bit gave no service request");

   srq_cause_a: assert property (
      $rose(srq) |-> $past(req))
      else $error("service request raised without cause");

   sre_store_a: assert property (
      cmd.valid && cmd.op == sbsr_pkg::OP_SRE_WR
         ##1 cmd.valid && cmd.op == sbsr_pkg::OP_SRE_RD
         |=> rsp.valid && rsp.data == $past(cmd.data, 2))
      else $error("request enable mask not returned");

   dev_bit_a: assert property (
      ##1 stb_full[sbsr_pkg::BIT_DEV] == $past(|(dev.evt & dev.ena)))
      else $error("device status summary bit wrong");

   eav_push_a: assert property (
      err_push && sre_r[sbsr_pkg::BIT_EAV] |=> srq)
      else $error("error queue entry gave no service request");

   eav_bit_a: assert property (
      ##1 stb_full[sbsr_pkg::BIT_EAV] == $past(err_not_empty))
      else $error("error queue bit wrong");

   ques_bit_a: assert property (
      ##1 stb_full[sbsr_pkg::BIT_QUES] == $past(|(ques.evt & ques.ena)))
      else $error("questionable summary bit wrong");

   mav_bit_a: assert property (
      ##1 stb_full[sbsr_pkg::BIT_MAV] == $past(msg_avail))
      else $error("message available bit wrong");

   esb_bit_a: assert property (
      ##1 stb_full[sbsr_pkg::BIT_ESB] == $past(|(esr.evt & esr.ena)))
      else $error("standard event summary bit wrong");

   oper_bit_a: assert property (
      ##1 stb_full[sbsr_pkg::BIT_OPER] == $past(|(oper.evt & oper.ena)))
      else $error("operation summary bit wrong");

   ist_flag_a: assert property (
      ##1 ist == |($past(stb_full) & $past(ppe_r)))
      else $error("poll flag does not match enabled bits");

   ist_reply_a: assert property (
      cmd.valid && (cmd.op == sbsr_pkg::OP_PPOLL
         || cmd.op == sbsr_pkg::OP_IST_RD)
         |=> rsp.valid && rsp.data == {7'h00, $past(ist)})
      else $error("poll flag answer wrong");

   pre_store_a: assert property (
      cmd.valid && cmd.op == sbsr_pkg::OP_PRE_WR
         ##1 cmd.valid && cmd.op == sbsr_pkg::OP_PRE_RD
         |=> rsp.valid && rsp.data == $past(cmd.data, 2))
      else $error("poll enable mask not returned");

   spoll_clear_a: assert property (
      spoll && !req |=> !srq)
      else $error("serial poll did not clear the request");

   srq_hold_a: assert property (
      srq && !spoll |=> srq)
      else $error("service request dropped without a serial poll");

   spoll_reply_a: assert property (
      spoll |=> rsp.valid && rsp.data == $past(stb_full))
      else $error("serial poll answer wrong");

   rsp_quiet_a: assert property (
      !rsp.valid |-> rsp.data == 8'h00)
      else $error("answer byte not zero while idle");

   write_silent_a: assert property (
      cmd.valid && (cmd.op == sbsr_pkg::OP_SRE_WR
         || cmd.op == sbsr_pkg::OP_PRE_WR) |=> !rsp.valid)
      else $error("mask write produced an answer");

   sre_keep_a: assert property (
      !(cmd.valid && cmd.op == sbsr_pkg::OP_SRE_WR) |=> $stable(sre_r))
      else $error("request enable mask changed without a write");

   ppe_keep_a: assert property (
      !(cmd.valid && cmd.op == sbsr_pkg::OP_PRE_WR) |=> $stable(ppe_r))
      else $error("poll enable mask changed without a write");

   spare_bit_a: assert property (
      !stb_full[1])
      else $error("unused status bit 1 is set");
endmodule

//--- dv/sbsr_host.sv
// Host controller model issuing common commands and polls
`timescale 1ns/1ps
module sbsr_host (
   input wire logic clk,
   output sbsr_pkg::sbsr_cmd_t cmd,
   input wire sbsr_pkg::sbsr_rsp_t rsp
);
   initial cmd = '0;
   // One idle cycle between commands keeps each strobe a clean pulse
   task automatic send(input sbsr_pkg::sbsr_op_t op, input logic [7:0] d);
      @(negedge clk);
      cmd <= '{valid: 1'b1, op: op, data: d};
      @(negedge clk);
      // Released data is inverted so a stale byte cannot look valid
      cmd <= '{valid: 1'b0, op: op, data: ~d};
   endtask
   task automatic ask(input sbsr_pkg::sbsr_op_t op, output logic [7:0] q);
      send(op, 8'h00);
      q = rsp.valid ? rsp.data : 8'hxx;
   endtask
endmodule

//--- dv/tb_top.sv
// Self-checking bench for the status byte block
`timescale 1ns/1ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin num_errors++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, b); end end
module tb_top;
   logic clk, rst_n, err_not_empty, err_push, msg_avail, srq, ist;
   logic [7:0] q;
   sbsr_pkg::sbsr_cmd_t cmd;
   sbsr_pkg::sbsr_scpi_t dev, ques, oper;
   sbsr_pkg::sbsr_esr_t esr;
   sbsr_pkg::sbsr_rsp_t rsp;
   int num_errors = 0;
   int n_checks = 0;
   int cyc = 0;
   sbsr_top dut_u (.clk(clk), .rst_n(rst_n), .cmd(cmd), .dev(dev),
      .ques(ques), .oper(oper), .esr(esr), .err_not_empty(err_not_empty),
      .err_push(err_push), .msg_avail(msg_avail), .rsp(rsp), .srq(srq),
      .ist(ist));
   sbsr_host host_u (.clk(clk), .cmd(cmd), .rsp(rsp));
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end
   task automatic stop_test();
      $display("errors=%0d checks=%0d", num_errors, n_checks);
      if (num_errors == 0 && n_checks > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
   endtask
   // Whole run needs about 130 cycles
   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         num_errors++;
         stop_test();
      end
   end
   task automatic nclk(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic ask_chk(input sbsr_pkg::sbsr_op_t op, input logic [7:0] e);
      host_u.ask(op, q);
      `CHK(q, e)
   endtask
   // Drives the lower-level source that feeds status bit b
   task automatic src(input int b, input logic on);
      case (b)
         0: dev = on ? {16'h0004, 16'h0004} : '0;
         2: err_not_empty = on;
         3: ques = on ? {16'h0200, 16'h0200} : '0;
         4: msg_avail = on;
         5: esr = on ? {8'h20, 8'h20} : '0;
         default: oper = on ? {16'h0010, 16'h0010} : '0;
      endcase
   endtask
   initial begin
      rst_n = 1'b0;
      dev = '0;
      ques = '0;
      oper = '0;
      esr = '0;
      err_not_empty = 1'b0;
      err_push = 1'b0;
      msg_avail = 1'b0;
      nclk(16);
      rst_n = 1'b1;
      `CHK({srq, ist}, 2'b00)
      ask_chk(sbsr_pkg::OP_STB_RD, 8'h00);
      ask_chk(sbsr_pkg::OP_SRE_RD, 8'h00);
      ask_chk(sbsr_pkg::OP_PRE_RD, 8'h00);
      // Event without its enable must stay out of the byte
      ques = {16'h0010, 16'h0020};
      nclk(2);
      ask_chk(sbsr_pkg::OP_STB_RD, 8'h00);
      ques = '0;
      host_u.send(sbsr_pkg::OP_SRE_WR, 8'hbd);
      ask_chk(sbsr_pkg::OP_SRE_RD, 8'hbd);
      host_u.send(sbsr_pkg::OP_PRE_WR, 8'h40);
      ask_chk(sbsr_pkg::OP_PRE_RD, 8'h40);
      for (int i = 0; i < 8; i++) begin
         if (i != 1 && i != 6) begin
            src(i, 1'b1);
            nclk(3);
            `CHK(srq, 1'b1)
            `CHK(ist, 1'b1)
            ask_chk(sbsr_pkg::OP_STB_RD, (8'h01 << i) | 8'h40);
            ask_chk(sbsr_pkg::OP_SPOLL, (8'h01 << i) | 8'h40);
            `CHK(srq, 1'b0)
            ask_chk(sbsr_pkg::OP_IST_RD, 8'h01);
            ask_chk(sbsr_pkg::OP_PPOLL, 8'h01);
            src(i, 1'b0);
            nclk(2);
         end
      end
      host_u.send(sbsr_pkg::OP_SRE_WR, 8'h40);
      msg_avail = 1'b1;
      nclk(3);
      `CHK({srq, ist}, 2'b00)
      ask_chk(sbsr_pkg::OP_STB_RD, 8'h10);
      host_u.send(sbsr_pkg::OP_PRE_WR, 8'h10);
      nclk(2);
      `CHK(ist, 1'b1)
      msg_avail = 1'b0;
      host_u.send(sbsr_pkg::OP_SRE_WR, 8'h04);
      err_not_empty = 1'b1;
      nclk(3);
      `CHK(srq, 1'b1)
      ask_chk(sbsr_pkg::OP_SPOLL, 8'h44);
      err_push = 1'b1;
      nclk(1);
      err_push = 1'b0;
      `CHK(srq, 1'b1)
      stop_test();
   end
endmodule
